//--- core/csi2_gasket_pkg.sv
// Types shared by the camera receive gasket
package csi2_gasket_pkg;

  typedef struct packed {
    logic        valid;
    logic [7:0]  id;
    logic [31:0] word;
    logic        packetEnd;
    logic        lineMark;
    logic        frameEnd;
    logic        crcFail;
  } link_beat_type;

  typedef struct packed {
    logic [3:0]  valid;
    logic [7:0]  id;
    logic [15:0] data;
  } pix_beat_type;

  typedef enum logic [2:0] {
    SER_IDLE = 3'b001,
    SER_LOW  = 3'b010,
    SER_HIGH = 3'b100
  } ser_state_type;

endpackage

//--- core/csi2_gasket_regs.svh
// Register map, field positions and codes of the camera receive gasket
`ifndef CSI2_GASKET_REGS_SVH
`define CSI2_GASKET_REGS_SVH

`define OFS_TEST_CTRL_A     8'h00
`define OFS_TEST_CTRL_B     8'h04
`define OFS_SHUTDOWN_REL    8'h08
`define OFS_PHY_RESET_REL   8'h0c
`define OFS_CTRL_RESET_REL  8'h10
`define OFS_GASKET_CTRL     8'h14
`define OFS_LANE_COUNT      8'h18
`define OFS_IRQ_STATUS      8'h1c
`define OFS_IRQ_MASK        8'h20
`define OFS_PATH_STATUS     8'h24

`define BIT_TEST_CLEAR      0
`define BIT_TEST_CLOCK      1
`define BIT_TEST_ENABLE     16
`define BIT_RELEASE         0
`define BIT_SOFT_RESET      0
`define BIT_CLOCK_MODE      1
`define BIT_YUV_ORDER       2
`define BIT_RGB444_PACK     3

`define TEST_CODE_RANGE     8'h44
`define LANES_FOUR          2'h3
`define GAP_LIMIT           19'h40000

`define EV_FRAME_END        0
`define EV_CRC_ERROR        1
`define EV_FALSE_CRC        2
`define EV_BAD_TYPE         3
`define EV_PLL_SET          4
`define EV_WIDTH            5

`define DT_YUV420_FIRST     6'h18
`define DT_YUV422_8BIT      6'h1e
`define DT_YUV422_10BIT     6'h1f
`define DT_RGB444           6'h20
`define DT_RGB888           6'h24
`define DT_RAW6             6'h28
`define DT_RAW14            6'h2d

`endif

//--- core/csi2_receive_gasket_setup.sv
// Camera receive path: PHY test port, reset releases, erratum model and gasket
`timescale 1ns/1ps
`include "csi2_gasket_regs.svh"

module csi2_receive_gasket_setup
  import csi2_gasket_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic [7:0]    regAddr,
  input  wire logic [31:0]   regWrData,
  input  wire logic          regWr,
  input  wire logic          regRd,
  output logic      [31:0]   regRdData,
  output logic               irq,
  input  wire logic          linkClock,
  input  wire link_beat_type linkBeat,
  output logic               phyPowerRelease,
  output logic               phyResetReleaseBit,
  output logic               controllerResetReleaseBit,
  output logic      [7:0]    pllRange,
  output pix_beat_type       pixBeat,
  output logic               pixClockGate
);

  function automatic logic accepted(input logic [5:0] dt);
    accepted = (dt >= `DT_YUV420_FIRST && dt <= `DT_RGB888) ||
               (dt >= `DT_RAW6 && dt <= `DT_RAW14);
  endfunction

  function automatic logic [15:0] formatHalf(input logic [5:0] dt,
                                             input logic [15:0] half,
                                             input logic [3:0] ctrl);
    formatHalf = half;
    if (dt == `DT_RGB444) begin
      if (ctrl[`BIT_RGB444_PACK])
        formatHalf = {half[11:8], 1'b0, half[3:0], 2'b00, half[7:4], 1'b0};
      else
        formatHalf = {4'h0, half[11:0]};
    end else if (dt == `DT_YUV422_8BIT && ctrl[`BIT_YUV_ORDER]) begin
      formatHalf = {half[7:0], half[15:8]};
    end
  endfunction

  // Software registers
  logic [1:0]           testCtrlA;
  logic                 testEnable;
  logic [7:0]           testDataIn;
  logic [7:0]           testCode;
  logic                 shutdownRel;
  logic                 phyResetRel;
  logic                 ctrlResetRel;
  logic [3:0]           gasketCtrl;
  logic [1:0]           laneCount;
  logic [`EV_WIDTH-1:0] irqStatus;
  logic [`EV_WIDTH-1:0] irqMask;
  logic [`EV_WIDTH-1:0] events;

  // PHY test port model
  logic                 testClockPrev;
  logic                 pllSet;
  logic                 testFall;

  // Link sampling
  logic                 linkClkMeta;
  logic                 linkClkSync;
  logic                 linkClkPrev;
  link_beat_type        beatMeta;
  link_beat_type        beatSync;
  logic                 linkEdge;

  // Erratum payload counter
  logic [18:0]          payloadCount;
  logic                 inPacket;
  logic                 gapOverflow;
  logic                 sawLineMark;

  // Gasket path
  ser_state_type        serState;
  link_beat_type        held;
  logic                 pathReady;
  logic [15:0]          outHalf;
  logic [3:0]           chanValid;

  wire writeA = regWr && regAddr == `OFS_TEST_CTRL_A;
  wire writeB = regWr && regAddr == `OFS_TEST_CTRL_B;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      testCtrlA <= 2'h0;
      testEnable <= 1'b0;
      testDataIn <= 8'h00;
    end else begin
      if (writeA)
        testCtrlA <= regWrData[1:0];
      if (writeB) begin
        testEnable <= regWrData[`BIT_TEST_ENABLE];
        testDataIn <= regWrData[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      shutdownRel <= 1'b0;
      phyResetRel <= 1'b0;
      ctrlResetRel <= 1'b0;
      gasketCtrl <= 4'h0;
      laneCount <= 2'h0;
      irqMask <= '0;
    end else if (regWr) begin
      case (regAddr)
        `OFS_SHUTDOWN_REL:   shutdownRel <= regWrData[`BIT_RELEASE];
        `OFS_PHY_RESET_REL:  phyResetRel <= regWrData[`BIT_RELEASE];
        `OFS_CTRL_RESET_REL: ctrlResetRel <= regWrData[`BIT_RELEASE];
        `OFS_GASKET_CTRL:    gasketCtrl <= regWrData[3:0];
        `OFS_LANE_COUNT:     laneCount <= regWrData[1:0];
        `OFS_IRQ_MASK:       irqMask <= regWrData[`EV_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // Test data latch on the falling test clock; the clear bit wipes the test code
  assign testFall = testClockPrev && !testCtrlA[`BIT_TEST_CLOCK];

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      testClockPrev <= 1'b0;
      testCode <= 8'h00;
      pllRange <= 8'h00;
      pllSet <= 1'b0;
    end else begin
      testClockPrev <= testCtrlA[`BIT_TEST_CLOCK];
      if (testCtrlA[`BIT_TEST_CLEAR]) begin
        testCode <= 8'h00;
      end else if (testFall) begin
        if (testEnable)
          testCode <= testDataIn;
        else if (testCode == `TEST_CODE_RANGE) begin
          pllRange <= testDataIn;
          pllSet <= 1'b1;
        end
      end
    end
  end

  // Outputs follow the release bits in chain order; each also needs the releases before it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phyPowerRelease <= 1'b0;
      phyResetReleaseBit <= 1'b0;
      controllerResetReleaseBit <= 1'b0;
    end else begin
      phyPowerRelease <= shutdownRel;
      phyResetReleaseBit <= shutdownRel && phyResetRel;
      controllerResetReleaseBit <= shutdownRel && phyResetRel && ctrlResetRel;
    end
  end

  // Beat fields are held steady by the sender around the link clock edge, so
  // they ride the same two-stage delay as the clock and are read together.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      linkClkMeta <= 1'b0;
      linkClkSync <= 1'b0;
      linkClkPrev <= 1'b0;
      beatMeta <= '0;
      beatSync <= '0;
    end else begin
      linkClkMeta <= linkClock;
      linkClkSync <= linkClkMeta;
      linkClkPrev <= linkClkSync;
      beatMeta <= linkBeat;
      beatSync <= beatMeta;
    end
  end

  assign linkEdge = linkClkSync && !linkClkPrev;
  assign pathReady = pllSet && controllerResetReleaseBit && !gasketCtrl[`BIT_SOFT_RESET];

  // Models the four-lane counter that runs on past a long packet; it only
  // taints the CRC report, the data path below never looks at it.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      payloadCount <= 19'h0;
      inPacket <= 1'b0;
      gapOverflow <= 1'b0;
      sawLineMark <= 1'b0;
    end else if (!pathReady) begin
      payloadCount <= 19'h0;
      inPacket <= 1'b0;
      gapOverflow <= 1'b0;
      sawLineMark <= 1'b0;
    end else if (linkEdge) begin
      if (beatSync.lineMark)
        sawLineMark <= 1'b1;
      if (beatSync.valid) begin
        inPacket <= !beatSync.packetEnd;
        payloadCount <= beatSync.packetEnd ? 19'h0 : payloadCount + 19'h1;
        gapOverflow <= 1'b0;
      end else if (laneCount == `LANES_FOUR && !inPacket) begin
        if (payloadCount >= `GAP_LIMIT - 19'h1)
          gapOverflow <= 1'b1;
        else
          payloadCount <= payloadCount + 19'h1;
      end
      if (beatSync.frameEnd) begin
        sawLineMark <= 1'b0;
        gapOverflow <= 1'b0;
        payloadCount <= 19'h0;
      end
    end
  end

  always_comb begin
    events = '0;
    if (linkEdge && pathReady) begin
      events[`EV_FRAME_END] = beatSync.frameEnd;
      events[`EV_CRC_ERROR] = beatSync.valid && beatSync.packetEnd && beatSync.crcFail;
      events[`EV_FALSE_CRC] = beatSync.frameEnd && gapOverflow && !sawLineMark;
      events[`EV_BAD_TYPE] = beatSync.valid && !accepted(beatSync.id[5:0]);
    end
    events[`EV_PLL_SET] = testFall && !testEnable && !testCtrlA[`BIT_TEST_CLEAR] &&
                          testCode == `TEST_CODE_RANGE;
  end

  // A new event outranks a same-cycle write-one clear
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      irqStatus <= '0;
      irq <= 1'b0;
    end else begin
      if (regWr && regAddr == `OFS_IRQ_STATUS)
        irqStatus <= (irqStatus & ~regWrData[`EV_WIDTH-1:0]) | events;
      else
        irqStatus <= irqStatus | events;
      irq <= |(irqStatus & irqMask);
    end
  end

  // Split each accepted 32-bit word into two 16-bit beats, low half first; a link
  // word arrives at most every eight system clocks, so two slots suffice.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serState <= SER_IDLE;
      held <= '0;
    end else if (!pathReady) begin
      serState <= SER_IDLE;
    end else begin
      case (serState)
        SER_IDLE: begin
          if (linkEdge && beatSync.valid && accepted(beatSync.id[5:0])) begin
            held <= beatSync;
            serState <= SER_LOW;
          end
        end
        SER_LOW:  serState <= SER_HIGH;
        SER_HIGH: serState <= SER_IDLE;
        default:  serState <= SER_IDLE;
      endcase
    end
  end

  assign outHalf = (serState == SER_HIGH) ? held.word[31:16] : held.word[15:0];

  always_comb begin
    chanValid = 4'h0;
    if (serState == SER_LOW || serState == SER_HIGH)
      chanValid[held.id[7:6]] = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pixBeat <= '0;
      pixClockGate <= 1'b0;
    end else if (!pathReady) begin
      pixBeat <= '0;
      pixClockGate <= 1'b0;
    end else begin
      pixBeat.valid <= chanValid;
      pixBeat.id <= {2'b00, held.id[5:0]};
      pixBeat.data <= formatHalf(held.id[5:0], outHalf, gasketCtrl);
      pixClockGate <= gasketCtrl[`BIT_CLOCK_MODE] || (|chanValid);
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        `OFS_TEST_CTRL_A:    regRdData <= {30'h0, testCtrlA};
        `OFS_TEST_CTRL_B:    regRdData <= {15'h0, testEnable, testCode, testDataIn};
        `OFS_SHUTDOWN_REL:   regRdData <= {31'h0, shutdownRel};
        `OFS_PHY_RESET_REL:  regRdData <= {31'h0, phyResetRel};
        `OFS_CTRL_RESET_REL: regRdData <= {31'h0, ctrlResetRel};
        `OFS_GASKET_CTRL:    regRdData <= {28'h0, gasketCtrl};
        `OFS_LANE_COUNT:     regRdData <= {30'h0, laneCount};
        `OFS_IRQ_STATUS:     regRdData <= {27'h0, irqStatus};
        `OFS_IRQ_MASK:       regRdData <= {27'h0, irqMask};
        `OFS_PATH_STATUS:    regRdData <= {pllRange, 19'h0, serState, gapOverflow, pathReady};
        default:             regRdData <= 32'h0;
      endcase
    end else begin
      regRdData <= 32'h0;
    end
  end

endmodule

//--- tb/csi2_gasket_chk_sva.sv
// Port-level checker for the camera receive gasket
`timescale 1ns/1ps
`include "csi2_gasket_regs.svh"
module csi2_gasket_chk
  import csi2_gasket_pkg::*;
(
  input wire logic         clk_sys,
  input wire logic         sys_rst,
  input wire logic [7:0]   regAddr,
  input wire logic [31:0]  regWrData,
  input wire logic         regWr,
  input wire logic         regRd,
  input wire logic [31:0]  regRdData,
  input wire logic         irq,
  input wire logic         phyPowerRelease,
  input wire logic         phyResetReleaseBit,
  input wire logic         controllerResetReleaseBit,
  input wire pix_beat_type pixBeat,
  input wire logic         pixClockGate
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic ctrlWr;
  logic maskWr;
  assign ctrlWr = regWr && regAddr == `OFS_GASKET_CTRL;
  assign maskWr = regWr && regAddr == `OFS_IRQ_MASK;
  sequence halfPair;
    ##1 (pixBeat.valid == $past(pixBeat.valid)) ##1 (pixBeat.valid == 4'h0);
  endsequence
  // Margin of five quiet cycles lets a beat already in the pipe drain
  sequence softHold;
    ctrlWr && regWrData[0] ##1 (!ctrlWr) [*5];
  endsequence
  chk_half_pair: assert property ($rose(|pixBeat.valid) |-> halfPair)
    else $error("pixel halves not paired");
  chk_one_port: assert property ($onehot0(pixBeat.valid))
    else $error("beat on several ports");
  chk_vc_cleared: assert property (pixBeat.valid != 4'h0 |-> pixBeat.id[7:6] == 2'h0)
    else $error("channel bits not cleared");
  chk_type_kept: assert property (pixBeat.valid != 4'h0 |->
    pixBeat.id[5:0] inside {[6'h18:6'h24], [6'h28:6'h2d]}) else $error("bad type out");
  chk_release_chain: assert property ((!phyResetReleaseBit || phyPowerRelease) &&
    (!controllerResetReleaseBit || phyResetReleaseBit)) else $error("release out of order");
  chk_gate_beat: assert property (pixBeat.valid != 4'h0 |-> pixClockGate)
    else $error("clock gated during beat");
  chk_soft_quiet: assert property (softHold |-> pixBeat.valid == 4'h0)
    else $error("output during soft reset");
  chk_rd_idle: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside read cycle");
  chk_irq_masked: assert property (maskWr && regWrData == 32'h0 ##1 !maskWr |-> ##1 !irq)
    else $error("irq with all masked");
endmodule

//--- tb/csi2_receive_gasket_setup_tb.sv
// Register-driven bench for the camera receive gasket
`timescale 1ns/1ps
`include "csi2_gasket_regs.svh"
module csi2_receive_gasket_setup_tb
  import csi2_gasket_pkg::*;
;
  logic          clk_sys, sys_rst, regWr, regRd, linkClock, irq, pixClockGate;
  logic          phyPowerRelease, phyResetReleaseBit, controllerResetReleaseBit;
  logic [7:0]    regAddr, pllRange;
  logic [31:0]   regWrData, regRdData, rdv;
  link_beat_type linkBeat;
  pix_beat_type  pixBeat;
  pix_beat_type  got[$];
  int            n_fail, n_compared;
  logic [4:0]    beatFlags;

  csi2_receive_gasket_setup dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .irq(irq), .linkClock(linkClock), .linkBeat(linkBeat),
    .phyPowerRelease(phyPowerRelease), .phyResetReleaseBit(phyResetReleaseBit),
    .controllerResetReleaseBit(controllerResetReleaseBit), .pllRange(pllRange),
    .pixBeat(pixBeat), .pixClockGate(pixClockGate));
  csi2_sensor_model sensor_u (.linkClock(linkClock), .linkBeat(linkBeat));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (pixBeat.valid !== 4'h0) got.push_back(pixBeat);

  task automatic summarize;
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(posedge clk_sys);
    rdv = regRdData;
  endtask
  task automatic settle;
    repeat (2) @(posedge clk_sys);
  endtask
  // One link word in, expect two halves on port v, or no beat at all when v is zero
  task automatic beat(input logic [7:0] id, input logic [31:0] w, input logic [15:0] lo,
                      input logic [15:0] hi, input logic [3:0] v);
    got.delete();
    sensor_u.send(id, w, beatFlags);
    repeat (10) @(posedge clk_sys);
    chk("beatCount", (v == 4'h0) ? 0 : 2, got.size());
    if (v != 4'h0 && got.size() == 2) begin
      chk("pixValid", {v, v}, {got[0].valid, got[1].valid});
      chk("pixId", {2'h0, id[5:0]}, got[0].id);
      chk("pixData", {hi, lo}, {got[1].data, got[0].data});
    end
  endtask

  initial begin
    #200us;
    n_fail++;
    summarize;
  end

  initial begin
    logic [5:0] d;
    sys_rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0;
    beatFlags = 5'h1c;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk("release", 3'h0, {phyPowerRelease, phyResetReleaseBit, controllerResetReleaseBit});
    wr(`OFS_TEST_CTRL_A, 32'h0);
    wr(`OFS_TEST_CTRL_A, 32'h1);
    wr(`OFS_TEST_CTRL_B, 32'h0);
    wr(`OFS_TEST_CTRL_A, 32'h0);
    wr(`OFS_TEST_CTRL_A, 32'h2);
    wr(`OFS_TEST_CTRL_B, 32'h44);
    wr(`OFS_TEST_CTRL_B, 32'h10044);
    wr(`OFS_TEST_CTRL_A, 32'h0);
    wr(`OFS_TEST_CTRL_B, 32'h44);
    wr(`OFS_TEST_CTRL_B, 32'h14);
    wr(`OFS_TEST_CTRL_A, 32'h2);
    wr(`OFS_TEST_CTRL_A, 32'h0);
    rd(`OFS_TEST_CTRL_B);
    chk("testCode", 32'h4414, rdv);
    chk("pllRange", 8'h14, pllRange);
    for (int i = 0; i < 3; i++) begin
      wr(8'(`OFS_SHUTDOWN_REL + 4 * i), 32'h1);
      settle;
      chk("release", 3'(3'h7 << (2 - i)),
          {phyPowerRelease, phyResetReleaseBit, controllerResetReleaseBit});
    end
    for (int t = 8'h18; t <= 8'h2d; t++) begin
      d = 6'(t);
      if (t < 8'h25 || t > 8'h27)
        beat({d[1:0], d}, 32'h12345678, (d == `DT_RGB444) ? 16'h0678 : 16'h5678,
             (d == `DT_RGB444) ? 16'h0234 : 16'h1234, 4'(1 << d[1:0]));
    end
    wr(`OFS_GASKET_CTRL, 32'h8);
    beat(8'ha0, 32'hfabcf123, 16'h1184, 16'ha616, 4'h4);
    wr(`OFS_GASKET_CTRL, 32'h4);
    beat(8'hde, 32'h11223344, 16'h4433, 16'h2211, 4'h8);
    wr(`OFS_GASKET_CTRL, 32'hc);
    beat(8'h6a, 32'h12345678, 16'h5678, 16'h1234, 4'h2);
    beat(8'h70, 32'h12345678, 16'h0, 16'h0, 4'h0);
    wr(`OFS_LANE_COUNT, 32'h3);
    beatFlags = 5'h1d;
    beat(8'heb, 32'hcafe0123, 16'h0123, 16'hcafe, 4'h8);
    beatFlags = 5'h02;
    beat(8'heb, 32'h0, 16'h0, 16'h0, 4'h0);
    beatFlags = 5'h1c;
    rd(`OFS_IRQ_STATUS);
    chk("irqStatus", 32'h1b, rdv);
    chk("irqOff", 1'b0, irq);
    wr(`OFS_IRQ_MASK, 32'h8);
    settle;
    chk("irqOn", 1'b1, irq);
    wr(`OFS_IRQ_STATUS, 32'h1f);
    settle;
    chk("irqClear", 1'b0, irq);
    wr(`OFS_IRQ_MASK, 32'h0);
    rd(`OFS_IRQ_STATUS);
    chk("irqStatus", 32'h0, rdv);
    wr(`OFS_GASKET_CTRL, 32'h1);
    beat(8'h2a, 32'h12345678, 16'h0, 16'h0, 4'h0);
    wr(`OFS_GASKET_CTRL, 32'h2);
    settle;
    chk("freeClock", 1'b1, pixClockGate);
    beat(8'h2a, 32'h12345678, 16'h5678, 16'h1234, 4'h1);
    wr(`OFS_GASKET_CTRL, 32'h0);
    settle;
    chk("gatedClock", 1'b0, pixClockGate);
    rd(8'hfc);
    chk("unmapped", 32'h0, rdv);
    summarize;
  end
endmodule

bind csi2_receive_gasket_setup csi2_gasket_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .irq(irq), .phyPowerRelease(phyPowerRelease),
  .phyResetReleaseBit(phyResetReleaseBit),
  .controllerResetReleaseBit(controllerResetReleaseBit), .pixBeat(pixBeat),
  .pixClockGate(pixClockGate));

//--- tb/csi2_sensor_model.sv
// Camera sensor model driving the link clock and link beats
`timescale 1ns/1ps
module csi2_sensor_model
  import csi2_gasket_pkg::*;
(
  output logic          linkClock,
  output link_beat_type linkBeat
);
  initial begin
    linkClock = 1'b0;
    linkBeat = '0;
  end
  // Clock stands still between beats; released lanes show the inverse value.
  // Flags: valid, packet end, line mark, frame end, CRC fail.
  task automatic send(input logic [7:0] id, input logic [31:0] word, input logic [4:0] fl);
    linkBeat <= '{fl[4], id, word, fl[3], fl[2], fl[1], fl[0]};
    #40 linkClock <= 1'b1;
    #40 linkClock <= 1'b0;
    linkBeat.valid <= 1'b0;
    linkBeat.id <= ~id;
    linkBeat.word <= ~word;
  endtask
endmodule
